// File: rcs_pkg.sv
// Constants, register map and state encoding for the reset control sequencer.
package rcs_pkg;

  // Reset cause bit positions.
  localparam int CAUSE_W    = 6;
  localparam int CAUSE_EXT  = 0;
  localparam int CAUSE_POR  = 1;
  localparam int CAUSE_WDOG = 2;
  localparam int CAUSE_HALT = 3;
  localparam int CAUSE_LOC  = 4;
  localparam int CAUSE_TEST = 5;

  // Sequence lengths in system clocks.
  localparam logic [9:0] TURN_CYC     = 10'h002;
  localparam logic [9:0] DRIVE_CYC    = 10'h200;
  localparam logic [9:0] SETTLE1_CYC  = 10'h00A;
  localparam logic [9:0] SETTLE2_CYC  = 10'h0B4;
  localparam logic [9:0] POR_HOLD_CYC = 10'h004;
  localparam logic [2:0] EXT_LOW_CYC  = 3'h4;
  localparam logic [7:0] BUSMON_CYC   = 8'h40;

  // Register byte offsets.
  localparam logic [7:0] OFF_CAUSE  = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_CCR    = 8'h08;
  localparam logic [7:0] OFF_EXT    = 8'h0C;
  localparam logic [7:0] OFF_CTRL   = 8'h10;
  localparam logic [7:0] OFF_STATE  = 8'h14;

  // Condition code fields and their values after reset.
  localparam int         CCR_IPM_LSB  = 5;
  localparam int         CCR_SAT_BIT  = 4;
  localparam int         CCR_STOP_BIT = 15;
  localparam logic [2:0] IPM_RESET    = 3'h7;
  localparam logic [15:0] CCR_RESET   = 16'h80E0;
  localparam logic [15:0] EXT_RESET   = 16'h0000;
  localparam int         CTRL_TEST_BIT = 0;

  // Vector table: 256 two-byte vectors; four are fetched after reset.
  localparam int         VEC_COUNT      = 256;
  localparam int         VEC_TABLE_B    = 512;
  localparam logic [1:0] RESET_VEC_LAST = 2'h3;

  typedef enum logic [8:0] {
    RCS_POR   = 9'h001,
    RCS_RUN   = 9'h002,
    RCS_SYNCW = 9'h004,
    RCS_PINW  = 9'h008,
    RCS_TURN  = 9'h010,
    RCS_DRIVE = 9'h020,
    RCS_SET1  = 9'h040,
    RCS_SET2  = 9'h080,
    RCS_FETCH = 9'h100
  } rcs_state_t;

endpackage

// File: rcs_reset_sequencer.sv
// Reset control sequencer with AHB-Lite register access.
//
// Contract
// - Synchronous reset taken at bus cycle end, processing abandoned.
// - Reset overrides every other exception.
// - Requests synchronised; synchronous ones wait cycle end.
// - Synchronous reset enables bus monitor, ending hung cycles.
// - Pin, clock loss, test synchronous; others asynchronous.
// - Reset sets mask 7, stop disable, clears saturation, extension.
// - Other condition bits keep value across reset; power-on clears them.
// - Sample breakpoint, fetch four vectors, then run.
// - Vector table 256 two-byte vectors, 512 bytes.
// - Cause register updated at pin release, multi-bit.
// - Pin low four clocks latches external request.
// - Wait pin released, two clocks turnaround.
// - Drive reset pin low 512 clocks.
// - Synchronous internal reset waits cycle end, drives 512.
// - Asynchronous internal reset drives 512 immediately.
// - At drive end release pin, latch configuration.
// - Ten clocks later sample pin; high resumes fetch.
// - Still low: wait 180 clocks, sample again.
// - Still low: restart external reset sequence.
// - Power-on waits PLL lock before continuing.
// - External clock mode skips the lock wait.
// - Internal reset held at least four clocks.
// - Reset input synchronised; needs running clock.
// - First bus cycle ten clocks after release.
`timescale 1ns/1ps
module rcs_reset_sequencer #(
  parameter logic [7:0] BUSMON_LIMIT = rcs_pkg::BUSMON_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe_o,
  input  wire logic        pll_lock_i,
  input  wire logic        ext_clock_mode_i,
  input  wire logic        bus_error_input_i,
  input  wire logic        breakpoint_input_i,
  input  wire logic [15:0] data_i,
  input  wire logic        watchdog_timeout_i,
  input  wire logic        halt_monitor_i,
  input  wire logic        loss_of_clock_i,
  input  wire logic        test_reset_i,
  input  wire logic        bus_cycle_end_i,
  output logic             bus_monitor_en_o,
  output logic             bus_terminate_o,
  output logic             internal_reset_n_o,
  output logic             abort_exec_o,
  output logic             ebi_release_o,
  output logic             fetch_req_o,
  output logic      [7:0]  fetch_vec_o,
  output logic      [8:0]  fetch_disp_o,
  input  wire logic        fetch_ack_i,
  output logic             run_o,
  output logic             breakpoint_input_sample_o,
  output logic      [2:0]  interrupt_priority_mask_o,
  output logic             stop_disable_o,
  output logic             saturation_mode_bit_o,
  output logic      [15:0] ext_reg_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage feeds only the second.
  logic [20:0] sync_a;
  logic [20:0] sync_b;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync_a <= 21'h1F_FFFF;
      sync_b <= 21'h1F_FFFF;
    end
    else
    begin
      sync_a <= {rst_pin_i, pll_lock_i, ext_clock_mode_i, bus_error_input_i,
                 breakpoint_input_i, data_i};
      sync_b <= sync_a;
    end
  end
  wire        pin_s     = sync_b[20];
  wire        pll_s     = sync_b[19];
  wire        extclk_s  = sync_b[18];
  wire        bus_error_input_s    = sync_b[17];
  wire        breakpoint_input_s    = sync_b[16];
  wire [15:0] data_s    = sync_b[15:0];

  ////////////////////////////////////////////////////////////////////////////////
  // State, counters and cause tracking.
  rcs_pkg::rcs_state_t state;
  rcs_pkg::rcs_state_t next_state;
  logic [9:0] cnt;
  logic [7:0] bm_cnt;
  logic [2:0] low_cnt;
  logic [1:0] fetch_idx;
  logic [rcs_pkg::CAUSE_W-1:0] pend;
  logic [rcs_pkg::CAUSE_W-1:0] cause;
  logic [17:0] cfg;
  logic [15:0] ccr;
  logic [15:0] ext_reg;
  logic        sw_test;

  wire st_por   = (state == rcs_pkg::RCS_POR);
  wire st_run   = (state == rcs_pkg::RCS_RUN);
  wire st_syncw = (state == rcs_pkg::RCS_SYNCW);
  wire st_pinw  = (state == rcs_pkg::RCS_PINW);
  wire st_turn  = (state == rcs_pkg::RCS_TURN);
  wire st_drive = (state == rcs_pkg::RCS_DRIVE);
  wire st_set1  = (state == rcs_pkg::RCS_SET1);
  wire st_set2  = (state == rcs_pkg::RCS_SET2);
  wire st_fetch = (state == rcs_pkg::RCS_FETCH);
  wire active   = st_run | st_fetch;

  // External pin counts as a request only after four low samples while running or fetching vectors.
  wire ext_hit  = active & !pin_s & (low_cnt == rcs_pkg::EXT_LOW_CYC - 3'h1);
  wire restart  = st_set2 & (cnt == rcs_pkg::SETTLE2_CYC - 10'h001) & !pin_s;
  wire drive_end = st_drive & (cnt == rcs_pkg::DRIVE_CYC - 10'h001);
  wire [rcs_pkg::CAUSE_W-1:0] set_ev = {test_reset_i | sw_test, loss_of_clock_i,
                                        halt_monitor_i, watchdog_timeout_i, 1'b0,
                                        ext_hit | restart};
  wire [rcs_pkg::CAUSE_W-1:0] cap  = pend | set_ev;
  wire async_req = pend[rcs_pkg::CAUSE_WDOG] | pend[rcs_pkg::CAUSE_HALT];
  wire sync_req  = pend[rcs_pkg::CAUSE_EXT] | pend[rcs_pkg::CAUSE_LOC]
                 | pend[rcs_pkg::CAUSE_TEST];
  wire bm_to     = (bm_cnt == BUSMON_LIMIT - 8'h01);
  wire cyc_done  = bus_cycle_end_i | bm_to;
  wire enter_rst = active & (async_req | sync_req);
  logic        dph_wr;
  logic [7:0]  dph_addr;
  wire         aph      = hsel_i & htrans_i[1] & hready_i;
  wire [31:0]  dph_wdata = hwdata_i;
  wire         wr_ccr   = dph_wr & (dph_addr == rcs_pkg::OFF_CCR);
  wire         wr_ext   = dph_wr & (dph_addr == rcs_pkg::OFF_EXT);
  wire         wr_ctrl  = dph_wr & (dph_addr == rcs_pkg::OFF_CTRL);
  wire [7:0]   ra       = {haddr_i[7:2], 2'b00};
  wire [31:0]  rd_mux   =
    (ra == rcs_pkg::OFF_CAUSE)  ? {26'h000_0000, cause} :
    (ra == rcs_pkg::OFF_CONFIG) ? {14'h0000, cfg} :
    (ra == rcs_pkg::OFF_CCR)    ? {16'h0000, ccr} :
    (ra == rcs_pkg::OFF_EXT)    ? {16'h0000, ext_reg} :
    (ra == rcs_pkg::OFF_STATE)  ? {23'h00_0000, state} : 32'h0000_0000;

  always_comb
  begin
    next_state = state;
    case (state)
      rcs_pkg::RCS_POR:
        if ((pll_s | extclk_s) && cnt >= rcs_pkg::POR_HOLD_CYC - 10'h001)
          next_state = rcs_pkg::RCS_DRIVE;
      rcs_pkg::RCS_RUN, rcs_pkg::RCS_FETCH:
        if (async_req)
          next_state = rcs_pkg::RCS_DRIVE;
        else if (sync_req)
          next_state = rcs_pkg::RCS_SYNCW;
        else if (st_fetch && fetch_ack_i && fetch_idx == rcs_pkg::RESET_VEC_LAST)
          next_state = rcs_pkg::RCS_RUN;
      rcs_pkg::RCS_SYNCW:
        if (async_req)
          next_state = rcs_pkg::RCS_DRIVE;
        else if (cyc_done)
          next_state = pend[rcs_pkg::CAUSE_EXT] ? rcs_pkg::RCS_PINW
                                                : rcs_pkg::RCS_DRIVE;
      rcs_pkg::RCS_PINW:
        if (pin_s)
          next_state = rcs_pkg::RCS_TURN;
      rcs_pkg::RCS_TURN:
        if (cnt == rcs_pkg::TURN_CYC - 10'h001)
          next_state = rcs_pkg::RCS_DRIVE;
      rcs_pkg::RCS_DRIVE:
        if (drive_end)
          next_state = rcs_pkg::RCS_SET1;
      rcs_pkg::RCS_SET1:
        if (cnt == rcs_pkg::SETTLE1_CYC - 10'h001)
          next_state = pin_s ? rcs_pkg::RCS_FETCH : rcs_pkg::RCS_SET2;
      rcs_pkg::RCS_SET2:
        if (cnt == rcs_pkg::SETTLE2_CYC - 10'h001)
          next_state = pin_s ? rcs_pkg::RCS_FETCH : rcs_pkg::RCS_PINW;
      default:
        next_state = rcs_pkg::RCS_POR;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state   <= rcs_pkg::RCS_POR;
      cnt     <= 10'h000;
      bm_cnt  <= 8'h00;
      low_cnt <= 3'h0;
      pend    <= 6'h02;
      cause   <= 6'h00;
    end
    else
    begin
      state   <= next_state;
      cnt     <= (next_state != state) ? 10'h000 : (&cnt) ? cnt : cnt + 10'h001;
      bm_cnt  <= st_syncw ? bm_cnt + 8'h01 : 8'h00;
      low_cnt <= (active & !pin_s & !ext_hit) ? low_cnt + 3'h1 : 3'h0;
      // New events win over the clear at pin release.
      pend    <= drive_end ? set_ev : cap;
      if (drive_end)
        cause <= cap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Processor state, configuration latch and vector fetch.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ccr       <= rcs_pkg::CCR_RESET;
      ext_reg   <= rcs_pkg::EXT_RESET;
      cfg       <= 18'h0_0000;
      fetch_idx <= 2'h0;
      breakpoint_input_sample_o <= 1'b0;
    end
    else
    begin
      if (enter_rst)
      begin
        ccr[rcs_pkg::CCR_IPM_LSB +: 3] <= rcs_pkg::IPM_RESET;
        ccr[rcs_pkg::CCR_STOP_BIT]     <= 1'b1;
        ccr[rcs_pkg::CCR_SAT_BIT]      <= 1'b0;
        ext_reg                        <= rcs_pkg::EXT_RESET;
      end
      else if (wr_ccr)
        ccr <= dph_wdata[15:0];
      else if (wr_ext)
        ext_reg <= dph_wdata[15:0];
      if (drive_end)
        cfg <= {bus_error_input_s, breakpoint_input_s, data_s};
      if (next_state == rcs_pkg::RCS_FETCH && !st_fetch)
        breakpoint_input_sample_o <= breakpoint_input_s;
      if (!st_fetch)
        fetch_idx <= 2'h0;
      else if (fetch_ack_i)
        fetch_idx <= fetch_idx + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs, decoded from the next state except abort_exec_o, bus_terminate_o and rst_pin_o, which is held low.
  wire ns_drive = (next_state == rcs_pkg::RCS_DRIVE);
  wire ns_fetch = (next_state == rcs_pkg::RCS_FETCH);
  wire ns_run   = (next_state == rcs_pkg::RCS_RUN);
  wire ns_por_hold = (next_state == rcs_pkg::RCS_POR) && (cnt < rcs_pkg::POR_HOLD_CYC);
  wire ns_int_rst = !(ns_fetch | ns_run) &&
                    !((next_state == rcs_pkg::RCS_POR) && !ns_por_hold);
  wire [1:0] ns_idx = (!ns_fetch) ? 2'h0 : (st_fetch & fetch_ack_i) ? fetch_idx + 2'h1
                                                                    : fetch_idx;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_pin_o          <= 1'b0;
      rst_pin_oe_o       <= 1'b1;
      bus_monitor_en_o   <= 1'b0;
      bus_terminate_o    <= 1'b0;
      internal_reset_n_o <= 1'b0;
      abort_exec_o       <= 1'b0;
      ebi_release_o      <= 1'b0;
      fetch_req_o        <= 1'b0;
      fetch_vec_o        <= 8'h00;
      fetch_disp_o       <= 9'h000;
      run_o              <= 1'b0;
    end
    else
    begin
      rst_pin_o          <= 1'b0;
      rst_pin_oe_o       <= ns_drive | (next_state == rcs_pkg::RCS_POR);
      bus_monitor_en_o   <= (next_state == rcs_pkg::RCS_SYNCW);
      bus_terminate_o    <= st_syncw & bm_to & !bus_cycle_end_i & !async_req;
      internal_reset_n_o <= !ns_int_rst;
      abort_exec_o       <= enter_rst;
      ebi_release_o      <= ns_fetch | ns_run;
      fetch_req_o        <= ns_fetch;
      fetch_vec_o        <= {6'h00, ns_idx};
      fetch_disp_o       <= {7'h00, ns_idx} << 1;
      run_o              <= ns_run;
    end
  end

  assign interrupt_priority_mask_o = ccr[rcs_pkg::CCR_IPM_LSB +: 3];
  assign stop_disable_o            = ccr[rcs_pkg::CCR_STOP_BIT];
  assign saturation_mode_bit_o     = ccr[rcs_pkg::CCR_SAT_BIT];
  assign ext_reg_o                 = ext_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY.

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dph_wr      <= 1'b0;
      dph_addr    <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      sw_test     <= 1'b0;
    end
    else
    begin
      dph_wr      <= aph & hwrite_i;
      dph_addr    <= ra;
      hrdata_o    <= (aph & !hwrite_i) ? rd_mux : 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      sw_test     <= wr_ctrl & dph_wdata[rcs_pkg::CTRL_TEST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [10:0] oe_len;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      oe_len <= 11'h000;
    else
      oe_len <= st_drive ? oe_len + 11'h001 : 11'h000;
  end

  property p_drive_len;
    @(posedge clk_i) disable iff (!nrst_i) $fell(st_drive) |-> $past(oe_len) == 11'h1FF;
  endproperty
  a_drive_len: assert property (p_drive_len) else $error("pin drive not 512 clocks");

  property p_turn;
    @(posedge clk_i) disable iff (!nrst_i) $rose(st_turn) |-> st_turn[*2] ##1 st_drive;
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround not two clocks");

  property p_settle1;
    @(posedge clk_i) disable iff (!nrst_i)
      $rose(st_set1) |-> st_set1[*8] ##1 st_set1 ##1 st_set1 ##1 (st_fetch | st_set2);
  endproperty
  a_settle1: assert property (p_settle1) else $error("first sample not after ten");

  property p_set2_low;
    @(posedge clk_i) disable iff (!nrst_i) restart |=> st_pinw && pend[rcs_pkg::CAUSE_EXT];
  endproperty
  a_set2_low: assert property (p_set2_low) else $error("no restart on low pin");

  property p_async_now;
    @(posedge clk_i) disable iff (!nrst_i) (active & async_req) |=> st_drive ##1 rst_pin_oe_o;
  endproperty
  a_async_now: assert property (p_async_now) else $error("async reset delayed");

  property p_sync_wait;
    @(posedge clk_i) disable iff (!nrst_i)
      (st_syncw & !cyc_done & !async_req) |=> !st_drive && !st_pinw;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("sync reset before cycle end");

  property p_ccr_init;
    @(posedge clk_i) disable iff (!nrst_i) $past(enter_rst) |->
      interrupt_priority_mask_o == 3'h7 && stop_disable_o && !saturation_mode_bit_o
      && ext_reg_o == 16'h0000 && abort_exec_o;
  endproperty
  a_ccr_init: assert property (p_ccr_init) else $error("processor state not initialised");

  property p_cause;
    @(posedge clk_i) disable iff (!nrst_i) $fell(st_drive) |-> cause == $past(cap);
  endproperty
  a_cause: assert property (p_cause) else $error("cause register not updated");

  property p_ext_four;
    @(posedge clk_i) disable iff (!nrst_i) (st_run & !pin_s)[*4] |=> pend[rcs_pkg::CAUSE_EXT];
  endproperty
  a_ext_four: assert property (p_ext_four) else $error("external request not latched");

  property p_fetch_order;
    @(posedge clk_i) disable iff (!nrst_i)
      (st_fetch & fetch_ack_i & !enter_rst & fetch_idx != 2'h3) |=>
      fetch_idx == $past(fetch_idx) + 2'h1;
  endproperty
  a_fetch_order: assert property (p_fetch_order) else $error("vector order broken");

  c_restart: cover property (@(posedge clk_i) disable iff (!nrst_i) restart);
  c_second:  cover property (@(posedge clk_i) disable iff (!nrst_i) st_set2 ##1 st_fetch);
  c_busmon:  cover property (@(posedge clk_i) disable iff (!nrst_i) bus_terminate_o);
  c_run:     cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(run_o));

endmodule

// File: rcs_ext_reset_model.sv
// Model of the external reset source and the mode configuration drivers.
`timescale 1ns/1ps
module rcs_ext_reset_model #(
  parameter logic [15:0] CFG_DATA = 16'hA5C3,
  parameter logic        CFG_BREAKPOINT_INPUT = 1'b1,
  parameter logic        CFG_BUS_ERROR_INPUT = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        press_i,
  input  wire logic        dev_oe_i,
  output logic             pin_o,
  output logic      [15:0] data_o,
  output logic             breakpoint_input_o,
  output logic             bus_error_input_o
);
  logic [3:0] since_rel = 4'h0;
  logic       drive_cfg;

  // The wire is low while either party pulls it; the pull-up raises it otherwise.
  assign pin_o = !(dev_oe_i || press_i);

  always_ff @(posedge clk_i)
    if (!pin_o)
      since_rel <= 4'h0;
    else if (since_rel != 4'hF)
      since_rel <= since_rel + 4'h1;

  // Data drivers hold valid levels through release, then leave the bus to the weak pull-ups.
  assign drive_cfg = (since_rel < 4'h4);
  assign data_o    = drive_cfg ? CFG_DATA : 16'hFFFF;
  assign breakpoint_input_o    = CFG_BREAKPOINT_INPUT;
  assign bus_error_input_o    = CFG_BUS_ERROR_INPUT;
endmodule

// File: reset_control_sequencer_tb_top.sv
// Self-checking testbench for the reset control sequencer.
`timescale 1ns/1ps
module reset_control_sequencer_tb_top;
  localparam logic [15:0] CFG = 16'hA5C3;
  logic        clk_i, nrst_i, hsel_i, hwrite_i, pll_lock_i, watchdog_timeout_i;
  logic        halt_monitor_i, loss_of_clock_i, bus_cycle_end_i, fetch_ack_i, press;
  logic        hreadyout_o, hresp_o, rst_pin_i, rst_pin_o, rst_pin_oe_o, bus_error_input_i;
  logic        breakpoint_input_i, bus_monitor_en_o, bus_terminate_o, internal_reset_n_o;
  logic        abort_exec_o, ebi_release_o, fetch_req_o, run_o, breakpoint_input_sample_o;
  logic        stop_disable_o, saturation_mode_bit_o, test_reset_i, ext_clock_mode_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i, interrupt_priority_mask_o;
  logic [15:0] data_i, ext_reg_o;
  logic [7:0]  fetch_vec_o;
  logic [8:0]  fetch_disp_o;
  int          error_cnt, tests_run, n, aborts, terms, a0;

  rcs_reset_sequencer #(.BUSMON_LIMIT(8'h08)) rcs_reset_sequencer_inst (
    .clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .rst_pin_i, .rst_pin_o,
    .rst_pin_oe_o, .pll_lock_i, .ext_clock_mode_i, .bus_error_input_i,
    .breakpoint_input_i, .data_i, .watchdog_timeout_i, .halt_monitor_i, .loss_of_clock_i,
    .test_reset_i, .bus_cycle_end_i, .bus_monitor_en_o, .bus_terminate_o,
    .internal_reset_n_o, .abort_exec_o, .ebi_release_o, .fetch_req_o, .fetch_vec_o,
    .fetch_disp_o, .fetch_ack_i, .run_o, .breakpoint_input_sample_o, .interrupt_priority_mask_o,
    .stop_disable_o, .saturation_mode_bit_o, .ext_reg_o);

  rcs_ext_reset_model #(.CFG_DATA(CFG)) rcs_ext_reset_model_inst (
    .clk_i, .press_i(press), .dev_oe_i(rst_pin_oe_o), .pin_o(rst_pin_i),
    .data_o(data_i), .breakpoint_input_o(breakpoint_input_i), .bus_error_input_o(bus_error_input_i));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    if (abort_exec_o === 1'b1) aborts++;
    if (bus_terminate_o === 1'b1) terms++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic guard(input logic hit);
    if (hit !== 1'b1)
    begin
      chk("wait bound", 32'h0000_0000, 32'h0000_0001);
      complete_run();
    end
  endtask

  // One AHB-Lite single word transfer; read data lands in rd.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i  <= {24'h00_0000, a};
    hwrite_i <= wr;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 20);
    htrans_i <= 2'b00;
    hsel_i   <= 1'b0;
    hwdata_i <= wd;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 40);
    rd = hrdata_o;
    guard(hreadyout_o === 1'b1);
    chk("hresp", 32'h0000_0000, hresp_o);
  endtask

  task automatic wait_state(input logic [8:0] s, input int lim);
    int k;
    k = 0;
    do
    begin
      xfer(1'b0, rcs_pkg::OFF_STATE, 32'h0000_0000);
      k++;
    end while (rd[8:0] !== s && k < lim);
    guard(rd[8:0] === s);
  endtask

  task automatic oe_len();
    int k;
    k = 0;
    do
    begin
      @(negedge clk_i);
      k++;
    end while (rst_pin_oe_o !== 1'b1 && k < 2000);
    guard(rst_pin_oe_o === 1'b1);
    chk("internal reset low", 32'h0000_0000, internal_reset_n_o);
    chk("pin level", 32'h0000_0000, rst_pin_o);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end while (rst_pin_oe_o === 1'b1 && n < 2000);
    chk("drive length", 32'h0000_0200, n);
  endtask

  task automatic do_fetch();
    wait_state(9'h100, 200);
    chk("ebi release", 32'h0000_0001, ebi_release_o);
    chk("breakpoint_input sample", 32'h0000_0001, breakpoint_input_sample_o);
    for (int v = 0; v < 4; v++)
    begin
      @(negedge clk_i);
      chk("fetch req", 32'h0000_0001, fetch_req_o);
      chk("vector", v, fetch_vec_o);
      chk("displacement", 2 * v, fetch_disp_o);
      @(posedge clk_i);
      fetch_ack_i <= 1'b1;
      @(posedge clk_i);
      fetch_ack_i <= 1'b0;
    end
    @(negedge clk_i);
    chk("run", 32'h0000_0001, run_o);
  endtask

  task automatic regs(input logic [31:0] cause, input logic [31:0] ccr);
    xfer(1'b0, rcs_pkg::OFF_CAUSE, 32'h0000_0000);
    chk("cause", cause, rd);
    xfer(1'b0, rcs_pkg::OFF_CONFIG, 32'h0000_0000);
    chk("config", {15'h0000, 1'b1, CFG}, rd);
    xfer(1'b0, rcs_pkg::OFF_CCR, 32'h0000_0000);
    chk("ccr", ccr, rd);
    xfer(1'b0, rcs_pkg::OFF_EXT, 32'h0000_0000);
    chk("ext", 32'h0000_0000, rd);
  endtask

  task automatic pulse(input logic wd, input logic hm, input logic lc);
    @(posedge clk_i);
    watchdog_timeout_i <= wd;
    halt_monitor_i     <= hm;
    loss_of_clock_i    <= lc;
    @(posedge clk_i);
    watchdog_timeout_i <= 1'b0;
    halt_monitor_i     <= 1'b0;
    loss_of_clock_i    <= 1'b0;
  endtask

  task automatic sync_rst(input logic via_ctrl, input logic [31:0] cause);
    int t;
    t = terms;
    if (via_ctrl)
      xfer(1'b1, rcs_pkg::OFF_CTRL, 32'h0000_0001);
    else
      pulse(1'b0, 1'b0, 1'b1);
    repeat (4) @(negedge clk_i);
    chk("monitor on", 32'h0000_0001, bus_monitor_en_o);
    chk("pin waits", 32'h0000_0000, rst_pin_oe_o);
    if (via_ctrl)
    begin
      @(posedge clk_i);
      bus_cycle_end_i <= 1'b1;
      @(posedge clk_i);
      bus_cycle_end_i <= 1'b0;
    end
    oe_len();
    chk("terminations", t + (via_ctrl ? 0 : 1), terms);
    do_fetch();
    regs(cause, 32'h0000_80E3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk_i);
    chk("timeout", 32'h0000_0000, 32'h0000_0001);
    complete_run();
  end

  initial
  begin
    {nrst_i, hsel_i, hwrite_i, pll_lock_i, watchdog_timeout_i, halt_monitor_i} = '0;
    {loss_of_clock_i, test_reset_i, bus_cycle_end_i, fetch_ack_i, press, ext_clock_mode_i} = '0;
    {haddr_i, hwdata_i, htrans_i} = '0;
    hsize_i = 3'b010;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk("internal reset", 32'h0000_0000, internal_reset_n_o);
    repeat (40) @(negedge clk_i);
    chk("internal reset", 32'h0000_0001, internal_reset_n_o);
    chk("pin driven", 32'h0000_0001, rst_pin_oe_o);
    xfer(1'b0, rcs_pkg::OFF_STATE, 32'h0000_0000);
    chk("lock wait", 32'h0000_0001, rd);
    pll_lock_i <= 1'b1;
    do_fetch();
    regs(32'h0000_0002, 32'h0000_80E0);
    xfer(1'b1, rcs_pkg::OFF_CCR, 32'h0000_0013);
    xfer(1'b0, rcs_pkg::OFF_CCR, 32'h0000_0000);
    chk("ccr write", 32'h0000_0013, rd);
    xfer(1'b1, rcs_pkg::OFF_EXT, 32'h0000_1234);
    xfer(1'b0, rcs_pkg::OFF_EXT, 32'h0000_0000);
    chk("ext write", 32'h0000_1234, rd);
    a0 = aborts;
    pulse(1'b1, 1'b1, 1'b0);
    oe_len();
    chk("abort", a0 + 1, aborts);
    chk("mask", 32'h0000_0007, interrupt_priority_mask_o);
    chk("stop disable", 32'h0000_0001, stop_disable_o);
    chk("saturation", 32'h0000_0000, saturation_mode_bit_o);
    chk("ext out", 32'h0000_0000, ext_reg_o);
    do_fetch();
    regs(32'h0000_000C, 32'h0000_80E3);
    sync_rst(1'b1, 32'h0000_0020);
    sync_rst(1'b0, 32'h0000_0010);
    @(posedge clk_i);
    press <= 1'b1;
    repeat (3) @(posedge clk_i);
    press <= 1'b0;
    repeat (20) @(posedge clk_i);
    xfer(1'b0, rcs_pkg::OFF_STATE, 32'h0000_0000);
    chk("short press", 32'h0000_0002, rd);
    press <= 1'b1;
    repeat (30) @(posedge clk_i);
    xfer(1'b0, rcs_pkg::OFF_STATE, 32'h0000_0000);
    chk("pin wait", 32'h0000_0008, rd);
    press <= 1'b0;
    oe_len();
    do_fetch();
    regs(32'h0000_0001, 32'h0000_80E3);
    pulse(1'b0, 1'b1, 1'b0);
    oe_len();
    @(posedge clk_i);
    press <= 1'b1;
    repeat (50) @(posedge clk_i);
    xfer(1'b0, rcs_pkg::OFF_STATE, 32'h0000_0000);
    chk("second wait", 32'h0000_0080, rd);
    repeat (50) @(posedge clk_i);
    press <= 1'b0;
    do_fetch();
    regs(32'h0000_0008, 32'h0000_80E3);
    pulse(1'b1, 1'b0, 1'b0);
    oe_len();
    @(posedge clk_i);
    press <= 1'b1;
    repeat (220) @(posedge clk_i);
    xfer(1'b0, rcs_pkg::OFF_STATE, 32'h0000_0000);
    chk("restart", 32'h0000_0008, rd);
    press <= 1'b0;
    oe_len();
    do_fetch();
    regs(32'h0000_0001, 32'h0000_80E3);
    // Second power-on in external clock mode: no lock ever comes, yet the sequence runs.
    nrst_i           <= 1'b0;
    pll_lock_i       <= 1'b0;
    ext_clock_mode_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    do_fetch();
    regs(32'h0000_0002, 32'h0000_80E0);
    test_reset_i <= 1'b1;
    @(posedge clk_i);
    test_reset_i <= 1'b0;
    oe_len();
    do_fetch();
    regs(32'h0000_0020, 32'h0000_80E0);
    complete_run();
  end
endmodule
